// [bench/sdc_host.sv]
// Debug host model: issues decoded commands, collects read answers.
// Assumes the design answers reads one cycle after taking them.
`timescale 1ns/100ps
`default_nettype none
module sdc_host
    import sdc_pkg::*;
(
    input  wire logic       ref_clk_in, // Clock
    input  wire logic       rvalid_in,  // Answer strobe
    input  wire logic [7:0] rdata_in,   // Answer
    output var logic        valid_out,  // Command strobe
    output var logic [2:0]  kind_out,   // Code
    output var logic [1:0]  idx_out,    // Byte index
    output var logic [7:0]  wdata_out   // Data
);
    initial begin
        valid_out = 1'b0;
        kind_out = 3'h0;
        idx_out = 2'h0;
        wdata_out = 8'h00;
    end
    task automatic xfer(input sdc_cmd_e k, input logic [1:0] ix,
                        input logic [7:0] d, output logic [7:0] q);
        @(posedge ref_clk_in);
        valid_out <= 1'b1;
        kind_out <= k;
        idx_out <= ix;
        wdata_out <= d;
        @(posedge ref_clk_in);
        valid_out <= 1'b0;
        // Stale data must not look valid
        wdata_out <= ~d;
        q = 8'hXX;
        if (k == SDC_CMD_READ_STATUS || k == SDC_CMD_BKPT_READ) begin
            @(posedge ref_clk_in);
            q = (rvalid_in === 1'b1) ? rdata_in : 8'hXX;
        end
    endtask : xfer
endmodule : sdc_host
`default_nettype wire

// [bench/sdc_regs_checker.sv]
// Port assertions for sdc_regs.
// Bound into every sdc_regs instance; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module sdc_regs_checker
    import sdc_pkg::*;
(
    input wire logic       ref_clk_in,       // Clock
    input wire logic       rst_in,           // Reset
    input wire logic       cmd_valid_in,     // Command
    input wire logic [2:0] cmd_kind_in,      // Kind
    input wire logic [7:0] cmd_wdata_in,     // Data
    input wire logic [7:0] cmd_rdata_out,    // Read data
    input wire logic       cmd_rvalid_out,   // Read valid
    input wire logic       user_wr_in,       // User write
    input wire logic [7:0] user_rdata_out,   // User read
    input wire logic       cpu_wait_stop_in, // Wait/stop
    input wire logic       cpu_bgnd_in,      // Halted
    input wire logic       mem_done_in,      // Access end
    input wire logic       mem_wait_fail_in, // Cause
    input wire logic       mem_dv_fail_in,   // Cause
    input wire logic       fetch_in,         // Fetch
    input wire logic       bkpt_tag_out,     // Tag
    input wire logic       sys_rst_out       // Forced reset
);
    logic [1:0] ctl_r;
    logic [1:0] ctl_nxt;
    wire rd_st = cmd_valid_in && cmd_kind_in == SDC_CMD_READ_STATUS;
    wire frst = cmd_valid_in && cmd_kind_in == SDC_CMD_WRITE_FRST;
    // Shadow of enable and force/tag select
    always_comb begin
        ctl_nxt = ctl_r;
        if (cmd_valid_in && cmd_kind_in == SDC_CMD_WRITE_CONTROL) begin
            ctl_nxt = cmd_wdata_in[4:3];
        end
    end
    always_ff @(posedge ref_clk_in) begin
        ctl_r <= rst_in ? 2'h0 : ctl_nxt;
    end
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    sequence s_fail_read;
        mem_done_in ##1 !mem_done_in ##1 rd_st;
    endsequence
    sequence s_fire;
        frst && cmd_wdata_in[SDC_FR_BIT];
    endsequence
    a_user_zero:
    assert property (user_rdata_out == SDC_FR_READ_VAL)
        else $error("user read not zero");
    a_status_answer:
    assert property (rd_st |=> cmd_rvalid_out) else $error("no answer");
    a_reset_pulse:
    assert property (s_fire |=> sys_rst_out [*8] ##1 !sys_rst_out)
        else $error("forced reset length wrong");
    a_user_ignored:
    assert property (user_wr_in && !frst && !sys_rst_out |=> !sys_rst_out)
        else $error("user write reset");
    a_status_bits:
    assert property (rd_st |=> cmd_rdata_out[7:3] ==
        {1'b0, $past(cpu_bgnd_in), 1'b0, $past(ctl_r)})
        else $error("status control bits wrong");
    a_fail_flags:
    assert property (s_fail_read |=> cmd_rdata_out[1:0] ==
        {$past(mem_wait_fail_in, 3), $past(mem_dv_fail_in, 3)})
        else $error("fail flags wrong");
    a_wait_status:
    assert property (rd_st && cpu_wait_stop_in && $past(cpu_wait_stop_in)
        && !$past(rst_in) |=> cmd_rdata_out[SDC_SC_WAIT_STAT_BIT])
        else $error("wait status clear");
    a_tag_gate:
    assert property (bkpt_tag_out |-> ctl_r == 2'h2 && fetch_in)
        else $error("tag without enable");
endmodule : sdc_regs_checker
bind sdc_regs sdc_regs_checker i_chk (.ref_clk_in(ref_clk_in),
    .rst_in(rst_in), .cmd_valid_in(cmd_valid_in), .cmd_kind_in(cmd_kind_in),
    .cmd_wdata_in(cmd_wdata_in), .cmd_rdata_out(cmd_rdata_out),
    .cmd_rvalid_out(cmd_rvalid_out), .user_wr_in(user_wr_in),
    .user_rdata_out(user_rdata_out), .cpu_wait_stop_in(cpu_wait_stop_in),
    .cpu_bgnd_in(cpu_bgnd_in), .mem_done_in(mem_done_in),
    .mem_wait_fail_in(mem_wait_fail_in),
    .mem_dv_fail_in(mem_dv_fail_in),
    .fetch_in(fetch_in), .bkpt_tag_out(bkpt_tag_out),
    .sys_rst_out(sys_rst_out));
`default_nettype wire

// [bench/tb.sv]
// Self-checking bench for sdc_regs with a debug host model.
// Expected values come from a small model of the registers.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import sdc_pkg::*;
    logic clk, rst, cv, uwr, wsin, bgnd, halt, md, mws, mdv, fe, xt, bnd;
    logic rv, tag, bh, srst, m_wst;
    logic [2:0] kd;
    logic [1:0] ix, m_ctl, m_fl, c;
    logic [7:0] wd, rdat, urd, uwd, rd;
    logic [15:0] adr, bk;
    int n_errors, checked, cyc, i, n;
    sdc_host i_host (.ref_clk_in(clk), .rvalid_in(rv), .rdata_in(rdat),
        .valid_out(cv), .kind_out(kd), .idx_out(ix), .wdata_out(wd));
    sdc_regs i_dut (.ref_clk_in(clk), .rst_in(rst), .cmd_valid_in(cv),
        .cmd_kind_in(kd), .cmd_idx_in(ix), .cmd_wdata_in(wd),
        .cmd_rdata_out(rdat), .cmd_rvalid_out(rv), .user_wr_in(uwr),
        .user_wdata_in(uwd), .user_rdata_out(urd), .cpu_wait_stop_in(wsin),
        .cpu_bgnd_in(bgnd), .halt_cmd_in(halt), .mem_done_in(md),
        .mem_wait_fail_in(mws), .mem_dv_fail_in(mdv), .cpu_addr_in(adr),
        .fetch_in(fe), .exec_tag_in(xt), .boundary_in(bnd),
        .bkpt_tag_out(tag), .bkpt_halt_out(bh), .sys_rst_out(srst));
    task automatic chk(input logic [7:0] seen, exp, input string nm);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic st(input logic [1:0] fl);
        i_host.xfer(SDC_CMD_READ_STATUS, 2'h0, 8'h00, rd);
        chk(rd, {1'b0, bgnd, 1'b0, m_ctl, m_wst, fl}, "status");
    endtask : st
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            stop_test();
        end
    end
    initial begin
        rst = 1'b1;
        {uwr, wsin, bgnd, halt, md, mws, mdv, fe, xt, bnd, m_wst} = '0;
        {adr, uwd, m_ctl} = '0;
        i = $urandom(95);
        bk = 16'($urandom);
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        bgnd <= 1'b1;
        i_host.xfer(SDC_CMD_BKPT_WRITE, 2'h0, bk[15:8], rd);
        i_host.xfer(SDC_CMD_BKPT_WRITE, 2'h2, bk[7:0], rd);
        i_host.xfer(SDC_CMD_BKPT_WRITE, 2'h1, ~bk[7:0], rd);
        bgnd <= 1'b0;
        i_host.xfer(SDC_CMD_BKPT_READ, 2'h2, 8'h00, rd);
        chk(rd, bk[7:0], "bkpt low");
        i_host.xfer(SDC_CMD_BKPT_READ, 2'h0, 8'h00, rd);
        chk(rd, bk[15:8], "bkpt high");
        $display("test 1 done");
        for (i = 0; i < 5; i++) begin
            m_fl = 2'(i * 3);
            @(posedge clk);
            {md, mws, mdv} <= {1'b1, m_fl};
            @(posedge clk);
            {md, mws, mdv} <= {1'b0, ~m_fl};
            st(m_fl);
        end
        wsin <= 1'b1;
        repeat (2) @(posedge clk);
        m_wst = 1'b1;
        st(m_fl);
        {halt, bgnd, wsin} <= 3'h6;
        @(posedge clk);
        halt <= 1'b0;
        repeat (2) @(posedge clk);
        st(m_fl);
        bgnd <= 1'b0;
        repeat (2) @(posedge clk);
        m_wst = 1'b0;
        st(m_fl);
        $display("test 2 done");
        for (i = 0; i < 4; i++) begin
            c = 2'(i + 2);
            m_ctl = c;
            i_host.xfer(SDC_CMD_WRITE_CONTROL, 2'h0, {3'h0, c, 3'h0}, rd);
            st(m_fl);
            {fe, adr} <= {1'b1, bk};
            @(posedge clk);
            chk(8'(tag), 8'(c == 2'h2), "tag");
            {bnd, adr} <= {1'b1, bk ^ 16'h0001};
            @(posedge clk);
            chk(8'(bh), 8'(c == 2'h3), "force halt");
            chk(8'(tag), 8'h00, "tag miss");
            {bnd, fe, xt} <= {2'h0, c == 2'h2};
            @(posedge clk);
            if (c == 2'h2) chk(8'(bh), 8'h01, "tag halt");
            xt <= 1'b0;
        end
        $display("test 3 done");
        {uwr, uwd} <= {1'b1, 8'hFF};
        @(posedge clk);
        uwr <= 1'b0;
        repeat (3) @(posedge clk);
        chk(8'(srst), 8'h00, "user force");
        chk(urd, 8'h00, "user read");
        i_host.xfer(SDC_CMD_WRITE_FRST, 2'h0, 8'(bk) | 8'h01, rd);
        n = 0;
        repeat (12) begin
            @(posedge clk);
            n += int'(srst === 1'b1);
        end
        chk(8'(n), 8'(SDC_FRST_CYCLES), "reset length");
        $display("test 4 done");
        stop_test();
    end
endmodule : tb
`default_nettype wire

// [rtl/sdc_pkg.sv]
// Package for the serial debug controller register block.
// Holds offsets, bit positions, reset values and command codes.
package sdc_pkg;

    // Breakpoint register index space, reached by breakpoint commands only
    localparam logic [1:0] SDC_BKPT_HIGH_IDX   = 2'h0;
    localparam logic [1:0] SDC_BKPT_LOW_IDX    = 2'h2;

    // Debug status/control bit positions
    localparam int SDC_SC_DATA_FAIL_BIT = 0;
    localparam int SDC_SC_WAIT_FAIL_BIT = 1;
    localparam int SDC_SC_WAIT_STAT_BIT = 2;
    localparam int SDC_SC_FORCE_TAG_BIT = 3;
    localparam int SDC_SC_BKEN_BIT   = 4;
    localparam int SDC_SC_ACT_BIT    = 6;

    // Forced reset control
    localparam int SDC_FR_BIT        = 0;
    localparam logic [7:0] SDC_FR_READ_VAL = 8'h00;

    // Reset values
    localparam logic [7:0] SDC_BYTE_RST   = 8'h00;

    // Length of the forced system reset pulse, in clock cycles
    localparam logic [3:0] SDC_FRST_CYCLES = 4'h8;

    // Host command kinds
    typedef enum logic [2:0] {
        SDC_CMD_NONE,
        SDC_CMD_READ_STATUS,
        SDC_CMD_WRITE_CONTROL,
        SDC_CMD_BKPT_READ,
        SDC_CMD_BKPT_WRITE,
        SDC_CMD_WRITE_FRST
    } sdc_cmd_e;

endpackage : sdc_pkg

// [rtl/sdc_regs.sv]
// Serial debug controller registers: status/control, breakpoint address
// and forced reset. Host commands arrive already decoded, one a cycle.
// CPU state inputs are synchronous to ref_clk_in.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Wait/stop status reads 1 in wait/stop or after halt left it.
// - Wait/stop fail flag, bit 1, sets when access fails on wait/stop.
// - Data-valid fail flag, bit 0, follows slow-access conflict per command.
// - Breakpoint address held in two bytes; low at index 2.
// - Compare only when enable bit set; type from force/tag select.
// - Breakpoint bytes reached only by breakpoint commands, not user map.
// - Breakpoint commands accepted while user code runs.
// - Forced reset written only by debug command; user writes ignored.
// - Forced reset register always reads 0x00.
// - Forced reset bits 7..1 reserved, read zero.
// - Writing 1 to bit 0 by debug command forces system reset.
// - Force mode halts at next boundary; tag mode halts on execution.
module sdc_regs
    import sdc_pkg::*;
#(
    parameter int ADDR_W = 16
)
(
    input  wire logic              ref_clk_in,      // Core clock
    input  wire logic              rst_in,          // Sync reset, high
    input  wire logic              cmd_valid_in,    // Host command strobe
    input  wire logic [2:0]        cmd_kind_in,     // sdc_cmd_e code
    input  wire logic [1:0]        cmd_idx_in,      // Breakpoint byte index
    input  wire logic [7:0]        cmd_wdata_in,    // Write data
    output logic [7:0]             cmd_rdata_out,   // Read data, registered
    output logic                   cmd_rvalid_out,  // Read data valid
    input  wire logic              user_wr_in,      // User write to force reg
    input  wire logic [7:0]        user_wdata_in,   // User write data
    output logic [7:0]             user_rdata_out,  // User read of force reg
    input  wire logic              cpu_wait_stop_in,// CPU in wait or stop
    input  wire logic              cpu_bgnd_in,     // CPU in debug halt
    input  wire logic              halt_cmd_in,     // Halt command taken
    input  wire logic              mem_done_in,     // Memory command ended
    input  wire logic              mem_wait_fail_in,// Failed on wait/stop
    input  wire logic              mem_dv_fail_in,  // Failed on slow access
    input  wire logic [ADDR_W-1:0] cpu_addr_in,     // CPU address bus
    input  wire logic              fetch_in,        // Opcode fetch cycle
    input  wire logic              exec_tag_in,     // Tagged opcode executes
    input  wire logic              boundary_in,     // Instruction boundary
    output logic                   bkpt_tag_out,    // Tag fetched opcode
    output logic                   bkpt_halt_out,   // Enter debug halt
    output logic                   sys_rst_out      // Forced system reset
);

    // Breakpoint compare is a fixed pair of bytes
    if (ADDR_W != 16) begin : g_addr_w_check
        $error("sdc_regs supports a 16-bit address only");
    end

    logic [7:0] bkpt_hi_r,  bkpt_hi_nxt;
    logic [7:0] bkpt_lo_r,  bkpt_lo_nxt;
    logic       bken_r,     bken_nxt;
    logic       force_tag_r, force_tag_nxt;
    logic       wait_stop_r, wait_stop_nxt;
    logic       wait_fail_r, wait_fail_nxt;
    logic       data_fail_r, data_fail_nxt;
    logic       pend_r,     pend_nxt;
    logic [7:0] rdata_r,    rdata_nxt;
    logic       rvalid_r,   rvalid_nxt;
    logic       fire;
    logic       hit;
    logic [7:0] status;

    sdc_cmd_e cmd;
    assign cmd = sdc_cmd_e'(cmd_kind_in);

    assign status = {1'b0, cpu_bgnd_in, 1'b0, bken_r, force_tag_r,
                     wait_stop_r, wait_fail_r, data_fail_r};

    // Comparison is live only with the enable bit set
    assign hit = bken_r && (cpu_addr_in == {bkpt_hi_r, bkpt_lo_r});

    // Status group: wait/stop state and access failure flags
    always_comb begin
        wait_stop_nxt = wait_stop_r;
        wait_fail_nxt = wait_fail_r;
        data_fail_nxt = data_fail_r;

        // Stays set while halted if halt pulled the CPU out of wait/stop
        if (cpu_wait_stop_in) begin
            wait_stop_nxt = 1'b1;
        end else if (halt_cmd_in && wait_stop_r) begin
            wait_stop_nxt = 1'b1;
        end else if (!cpu_bgnd_in) begin
            wait_stop_nxt = 1'b0;
        end

        // Reloaded on every access, so a clean one clears an old failure
        if (mem_done_in) begin
            wait_fail_nxt = mem_wait_fail_in;
            data_fail_nxt = mem_dv_fail_in;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            wait_stop_r <= 1'b0;
            wait_fail_r <= 1'b0;
            data_fail_r <= 1'b0;
        end else begin
            wait_stop_r <= wait_stop_nxt;
            wait_fail_r <= wait_fail_nxt;
            data_fail_r <= data_fail_nxt;
        end
    end

    // Breakpoint group: address bytes, control bits, force pending
    always_comb begin
        bkpt_hi_nxt   = bkpt_hi_r;
        bkpt_lo_nxt   = bkpt_lo_r;
        bken_nxt      = bken_r;
        force_tag_nxt = force_tag_r;
        pend_nxt      = pend_r;

        // Force mode waits for a boundary; tag mode waits for execution
        if (hit && force_tag_r) begin
            pend_nxt = 1'b1;
        end
        // A boundary consumes the pending match; halting drops it too
        if (boundary_in || cpu_bgnd_in) begin
            pend_nxt = hit && force_tag_r && !cpu_bgnd_in;
        end

        // Accepted whether or not the CPU is halted
        if (cmd_valid_in) begin
            case (cmd)
                SDC_CMD_WRITE_CONTROL: begin
                    bken_nxt      = cmd_wdata_in[SDC_SC_BKEN_BIT];
                    force_tag_nxt = cmd_wdata_in[SDC_SC_FORCE_TAG_BIT];
                end
                SDC_CMD_BKPT_WRITE: begin
                    // Index 1 and 3 name no byte and are dropped
                    if (cmd_idx_in == SDC_BKPT_LOW_IDX) begin
                        bkpt_lo_nxt = cmd_wdata_in;
                    end else if (cmd_idx_in == SDC_BKPT_HIGH_IDX) begin
                        bkpt_hi_nxt = cmd_wdata_in;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            bkpt_hi_r   <= SDC_BYTE_RST;
            bkpt_lo_r   <= SDC_BYTE_RST;
            bken_r      <= 1'b0;
            force_tag_r <= 1'b0;
            pend_r      <= 1'b0;
        end else begin
            bkpt_hi_r   <= bkpt_hi_nxt;
            bkpt_lo_r   <= bkpt_lo_nxt;
            bken_r      <= bken_nxt;
            force_tag_r <= force_tag_nxt;
            pend_r      <= pend_nxt;
        end
    end

    // Answer group: read data, read strobe and the reset request
    always_comb begin
        rdata_nxt  = rdata_r;
        rvalid_nxt = 1'b0;
        fire       = 1'b0;

        if (cmd_valid_in) begin
            case (cmd)
                SDC_CMD_READ_STATUS: begin
                    rdata_nxt  = status;
                    rvalid_nxt = 1'b1;
                end
                SDC_CMD_BKPT_READ: begin
                    rdata_nxt  = (cmd_idx_in == SDC_BKPT_LOW_IDX) ?
                                 bkpt_lo_r : bkpt_hi_r;
                    rvalid_nxt = 1'b1;
                end
                // Only this debug path can start the reset pulse
                SDC_CMD_WRITE_FRST: begin
                    fire = cmd_wdata_in[SDC_FR_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            rdata_r  <= SDC_BYTE_RST;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    // Force mode: halt at the boundary ending the matching access
    assign bkpt_halt_out  = (pend_r && boundary_in && !cpu_bgnd_in)
                          || (exec_tag_in && !cpu_bgnd_in);
    assign bkpt_tag_out   = hit && !force_tag_r && fetch_in;
    assign cmd_rdata_out  = rdata_r;
    assign cmd_rvalid_out = rvalid_r;
    // User writes have no path into the force logic
    assign user_rdata_out = SDC_FR_READ_VAL;

    sdc_rst_pulse u_rst_pulse (
        .ref_clk_in  (ref_clk_in),
        .rst_in      (rst_in),
        .fire_in     (fire),
        .sys_rst_out (sys_rst_out)
    );

endmodule : sdc_regs

`default_nettype wire

// [rtl/sdc_rst_pulse.sv]
// Stretches a one-cycle force request into a system reset pulse.
// Assumes the requester drives a single-cycle strobe on ref_clk_in.
`timescale 1ns/100ps
`default_nettype none

module sdc_rst_pulse
    import sdc_pkg::*;
(
    input  wire logic ref_clk_in,   // Core clock
    input  wire logic rst_in,       // Sync reset, high
    input  wire logic fire_in,      // Start pulse
    output logic      sys_rst_out   // Reset request
);

    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        if (fire_in) begin
            cnt_nxt = SDC_FRST_CYCLES;
        end else if (cnt_r != 4'h0) begin
            cnt_nxt = cnt_r - 4'h1;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            cnt_r <= 4'h0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // The forced reset must not feed rst_in here, or the pulse would
    // cut itself short after one cycle.
    assign sys_rst_out = (cnt_r != 4'h0);

endmodule : sdc_rst_pulse

`default_nettype wire
